// ---- src/timer_pin_io.sv ----
// Purpose: 8-bit down-counter timer with 6-bit prescaler and pin modes
// Assumes: register writes are one-cycle strobes from the processor
// Notes: the internal clock is i_clk_sys; the pin mux sits here too
// Operation
// - mode bits 7:6 pick pin source: 00 port data, 10 toggle
// - mode bits 7:6 equal 11 put the internal clock over two on the pin
// - writing load bit presets the output toggle to one
// - each count end inverts the toggle that drives the pin
// - port data writes ignored while pin is timer-owned; reads give level
// - mode bits 5:4 select external, gated, triggered or retriggerable
// - trigger edge loads prescaler and counter without software help
// - every input falling edge raises the input edge request
// - external mode counts each input falling edge
// - gated mode counts timer clock only while input is high
// - gated falling edge raises edge request; count end its own request
// - triggered mode starts on first falling edge; later edges ignored
// - triggered single pass clears enable at count end
// - triggered continuous keeps reloading until software clears enable
// - retrigger mode reloads on every falling edge
// - retrigger single pass clears enable at count end; edges ignored
// - retrigger continuous reloads on edges and requests every end
// - load bit copies initial values, clears itself next clock
// - timer clock is internal clock over four, one synchronous chain
// - prescaler bit 0 picks single pass or continuous reload
// - prescaler modulo bits 7:2, zero divides by 64, one passes
`timescale 1ns/1ps
`default_nettype none
`include "timer_pin_map.svh"
module timer_pin_io #(
	parameter int PRE_W = 6,
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	// register file access
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// port five context
	input wire logic [7:0] i_port_five_direction,
	input wire logic i_port_data_wr,
	input wire logic i_port_data_bit6,
	output logic o_port_bit6_level,
	// pins
	input wire logic i_timer_input_pin,
	output logic o_timer_output_pin,
	output logic o_timer_output_oe_n,
	// requests, one-cycle pulses
	output logic o_count_end_request,
	output logic o_input_edge_request
);
	// register addressing is fixed at a byte
	if (PRE_W != 6 || CNT_W != 8) begin : g_bad_width
		$error("timer_pin_io supports only a 6-bit prescaler, 8-bit counter");
	end

	logic [7:0] tmc_q;
	logic [7:0] pre_q;
	logic [CNT_W-1:0] init_q;
	logic load_q;
	logic en_q;
	logic [1:0] div_q;
	logic timer_output_pin_q;
	logic clk_out_q;
	logic port_data_q;
	timer_pin_pkg::arm_state_type st_q, st_d;

	pin_sample_if smp ();

	// synchronised input
	pin_sampler u_sampler (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_pin(i_timer_input_pin),
		.o_smp(smp.source)
	);

	// register decode
	wire wr = i_reg_wr & i_ce;
	wire tmc_wr = wr & (i_reg_addr == `OFS_TIMER_MODE_CONTROL);
	wire cnt_wr = wr & (i_reg_addr == `OFS_MAIN_DOWN_COUNTER);
	wire pre_wr = wr & (i_reg_addr == `OFS_PRESCALER_CONFIG);
	wire sw_load = tmc_wr & i_reg_wdata[`TMC_LOAD];
	wire sw_enable = tmc_wr & i_reg_wdata[`TMC_ENABLE];

	// mode fields
	timer_pin_pkg::in_mode_type in_mode;
	timer_pin_pkg::out_sel_type out_sel;
	assign in_mode = timer_pin_pkg::in_mode_type'(
		tmc_q[`TMC_IN_HI:`TMC_IN_LO]);
	assign out_sel = timer_pin_pkg::out_sel_type'(
		tmc_q[`TMC_OUT_HI:`TMC_OUT_LO]);
	wire pin_src = ~pre_q[`PRE_INT_SOURCE]; // input pin drives the chain
	wire continuous = pre_q[`PRE_CONTINUOUS];
	wire [PRE_W-1:0] pre_mod = pre_q[`PRE_MOD_HI:`PRE_MOD_LO];
	wire trig_mode = pin_src & in_mode[1];

	// divide-by-four, restarted by an enable write so the first
	// decrement lands four internal clocks later
	wire timer_tick = (div_q == `TIMER_DIV_LAST);

	// trigger arming: triggered fires once, retrigger on every edge
	wire trig_fire = trig_mode & en_q & smp.fall &
		((in_mode == timer_pin_pkg::IN_RETRIGGER) ||
		(st_q == timer_pin_pkg::ST_ARMED));

	// step source for the prescaler per input mode
	logic pre_step_src;
	always_comb begin
		if (!pin_src) begin
			pre_step_src = timer_tick;
		end else begin
			unique case (in_mode)
				timer_pin_pkg::IN_EXT_CLOCK:
					pre_step_src = smp.fall;
				timer_pin_pkg::IN_GATED:
					pre_step_src = timer_tick & smp.level;
				timer_pin_pkg::IN_TRIGGERED,
				timer_pin_pkg::IN_RETRIGGER:
					pre_step_src = timer_tick &
						(st_q == timer_pin_pkg::ST_RUN);
			endcase
		end
	end

	wire pre_step = en_q & pre_step_src & ~trig_fire;
	wire chain_load = load_q | trig_fire;
	logic pre_carry;
	logic cnt_end;
	logic [PRE_W-1:0] pre_count;
	logic [CNT_W-1:0] cnt_count;

	// prescaler always reloads on its own end
	reload_down_counter #(.W(PRE_W)) u_prescaler (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_load(chain_load),
		.i_step(pre_step),
		.i_auto(1'b1),
		.i_init(pre_mod),
		.o_count(pre_count),
		.o_end(pre_carry)
	);

	// main counter steps on prescaler carry, same edge: one chain
	reload_down_counter #(.W(CNT_W)) u_main_down_counter (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_load(chain_load),
		.i_step(pre_carry),
		.i_auto(continuous),
		.i_init(init_q),
		.o_count(cnt_count),
		.o_end(cnt_end)
	);

	// single pass in trigger modes drops enable at the end
	wire en_clear = cnt_end & trig_mode & ~continuous;

	// arming state next value
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			timer_pin_pkg::ST_IDLE:
				if (en_q && trig_mode) st_d = timer_pin_pkg::ST_ARMED;
			timer_pin_pkg::ST_ARMED:
				if (trig_fire) st_d = timer_pin_pkg::ST_RUN;
			timer_pin_pkg::ST_RUN:
				if (en_clear) st_d = timer_pin_pkg::ST_IDLE;
			default:
				st_d = timer_pin_pkg::ST_IDLE;
		endcase
		if (!en_q || !trig_mode) begin
			st_d = timer_pin_pkg::ST_IDLE;
		end
	end

	// pin source selection
	logic pin_d;
	always_comb begin
		unique case (out_sel)
			timer_pin_pkg::OUT_DATA,
			timer_pin_pkg::OUT_OTHER: pin_d = port_data_q;
			timer_pin_pkg::OUT_TOGGLE: pin_d = timer_output_pin_q;
			timer_pin_pkg::OUT_CLOCK: pin_d = clk_out_q;
		endcase
	end
	wire timer_owns_pin = out_sel[1];

	// read mux: counter reads show the live count
	logic [7:0] rdata_d;
	always_comb begin
		unique case (i_reg_addr)
			`OFS_TIMER_MODE_CONTROL: rdata_d = {tmc_q[7:4], en_q, load_q,
				tmc_q[1:0]};
			`OFS_MAIN_DOWN_COUNTER: rdata_d = cnt_count;
			`OFS_PRESCALER_CONFIG: rdata_d = pre_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// control registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			tmc_q <= `TMC_RESET;
			pre_q <= `PRE_RESET;
			init_q <= `CNT_RESET;
			load_q <= 1'b0;
			st_q <= timer_pin_pkg::ST_IDLE;
		end else if (i_ce) begin
			if (tmc_wr) tmc_q <= i_reg_wdata;
			if (pre_wr) pre_q <= i_reg_wdata;
			if (cnt_wr) init_q <= i_reg_wdata;
			load_q <= sw_load; // clears on the next clock
			st_q <= st_d;
		end
	end

	// enable: a software write wins over the end-of-pass clear
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			en_q <= 1'b0;
		end else if (i_ce) begin
			if (tmc_wr) en_q <= i_reg_wdata[`TMC_ENABLE];
			else if (en_clear) en_q <= 1'b0;
		end
	end

	// timer clock divider
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			div_q <= 2'h0;
		end else if (i_ce) begin
			div_q <= (sw_enable || chain_load) ? 2'h0 : div_q + 2'h1;
		end
	end

	// toggle: load preset has priority over a coincident end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			timer_output_pin_q <= 1'b1;
			clk_out_q <= 1'b0;
		end else if (i_ce) begin
			if (sw_load) timer_output_pin_q <= 1'b1;
			else if (cnt_end) timer_output_pin_q <= ~timer_output_pin_q;
			clk_out_q <= ~clk_out_q; // flop-limited clock image
		end
	end

	// port data latch is frozen while the timer owns the pin
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			port_data_q <= 1'b1;
		end else if (i_ce && i_port_data_wr && !timer_owns_pin) begin
			port_data_q <= i_port_data_bit6;
		end
	end

	// registered outputs
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_reg_rdata <= 8'h00;
			o_timer_output_pin <= 1'b1;
			o_port_bit6_level <= 1'b1;
			o_timer_output_oe_n <= 1'b1;
			o_count_end_request <= 1'b0;
			o_input_edge_request <= 1'b0;
		end else if (i_ce) begin
			o_reg_rdata <= rdata_d;
			o_timer_output_pin <= pin_d;
			o_port_bit6_level <= pin_d;
			o_timer_output_oe_n <= i_port_five_direction[`PORT_BIT_SIX];
			o_count_end_request <= cnt_end;
			o_input_edge_request <= smp.fall;
		end
	end

	// checks
	edge_request_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && smp.fall |=> o_input_edge_request)
		else $error("falling edge gave no edge request");
	load_clears_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && sw_load |=> load_q ##1 !load_q)
		else $error("load bit did not self clear");
	toggle_preset_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && sw_load |=> timer_output_pin_q)
		else $error("load did not preset the toggle");
	toggle_flip_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && cnt_end && !sw_load |=>
		timer_output_pin_q != $past(timer_output_pin_q))
		else $error("count end did not invert toggle");
	pin_toggle_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && out_sel == timer_pin_pkg::OUT_TOGGLE
		|=> o_timer_output_pin == $past(timer_output_pin_q))
		else $error("pin not following toggle");
	clock_out_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && out_sel == timer_pin_pkg::OUT_CLOCK
		##1 i_ce && out_sel == timer_pin_pkg::OUT_CLOCK
		|=> o_timer_output_pin != $past(o_timer_output_pin))
		else $error("clock image not toggling on the pin");
	port_frozen_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && timer_owns_pin |=> $stable(port_data_q))
		else $error("port write changed timer-owned pin");
	single_stop_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && en_clear && !tmc_wr |=> !en_q)
		else $error("single pass did not drop enable");
	single_rest_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && cnt_end && !continuous |=>
		cnt_count == 8'h00)
		else $error("single pass did not rest at zero");
	gate_hold_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) pin_src && in_mode == timer_pin_pkg::IN_GATED
		&& !smp.level |-> !pre_step)
		else $error("gated prescaler stepped while low");
	trig_once_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) st_q == timer_pin_pkg::ST_RUN &&
		in_mode == timer_pin_pkg::IN_TRIGGERED |-> !trig_fire)
		else $error("triggered mode restarted on later edge");
	trig_load_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && trig_fire |=>
		cnt_count == $past(init_q) && pre_count == $past(pre_mod))
		else $error("trigger edge did not load the counters");
	retrig_reload_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) pin_src && en_q && smp.fall &&
		in_mode == timer_pin_pkg::IN_RETRIGGER
		|=> cnt_count == $past(init_q))
		else $error("retrigger edge did not reload");
	tick_spacing_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_rstn) i_ce && timer_tick && !sw_enable && !chain_load
		##1 i_ce [*3] |-> !timer_tick)
		else $error("timer clock not divide by four");
endmodule // timer_pin_io
`default_nettype wire

// ---- src/timer_pin_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte-wide register file, one internal clock
// Notes: definitions only
`ifndef TIMER_PIN_MAP_SVH
`define TIMER_PIN_MAP_SVH
// register offsets
`define OFS_TIMER_MODE_CONTROL 8'hf1
`define OFS_MAIN_DOWN_COUNTER 8'hf2
`define OFS_PRESCALER_CONFIG 8'hf3
// timer_mode_control fields
`define TMC_LOAD 2
`define TMC_ENABLE 3
`define TMC_IN_LO 4
`define TMC_IN_HI 5
`define TMC_OUT_LO 6
`define TMC_OUT_HI 7
// prescaler_config fields
`define PRE_CONTINUOUS 0
`define PRE_INT_SOURCE 2
`define PRE_MOD_LO 2
`define PRE_MOD_HI 7
// port five pins
`define PORT_BIT_SIX 6
// reset values
`define TMC_RESET 8'h00
`define PRE_RESET 8'h00
`define CNT_RESET 8'h00
// timing: timer clock is the internal clock divided by four
`define CLK_PERIOD_NS 10
`define TIMER_CLK_DIV 4
`define TIMER_DIV_LAST 2'h3
`endif

// ---- src/timer_pin_pkg.sv ----
// Purpose: types shared by the timer pin block
// Assumes: nothing
// Notes: constants live in timer_pin_map.svh
package timer_pin_pkg;
	// input pin function, timer_mode_control bits 5:4
	typedef enum logic [1:0] {
		IN_EXT_CLOCK = 2'b00,
		IN_GATED = 2'b01,
		IN_TRIGGERED = 2'b10,
		IN_RETRIGGER = 2'b11
	} in_mode_type;
	// output pin source, timer_mode_control bits 7:6
	typedef enum logic [1:0] {
		OUT_DATA = 2'b00,
		OUT_OTHER = 2'b01,
		OUT_TOGGLE = 2'b10,
		OUT_CLOCK = 2'b11
	} out_sel_type;
	// trigger arming, gray along idle-armed-run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN = 2'b11
	} arm_state_type;
endpackage

// ---- src/pin_sample_if.sv ----
// Purpose: carries the sampled input pin between modules
// Assumes: one clock domain
// Notes: level and falling-edge pulse travel together
`timescale 1ns/1ps
`default_nettype none
interface pin_sample_if;
	logic level;
	logic fall;
	modport source (output level, fall);
	modport sink (input level, fall);
endinterface
`default_nettype wire

// ---- src/pin_sampler.sv ----
// Purpose: synchroniser and edge finder for the timer input pin
// Assumes: pin is asynchronous to the internal clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sampler (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	// pin
	input wire logic i_pin,
	// sampled view
	pin_sample_if.source o_smp
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// two-flop synchroniser then one history stage
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else if (i_ce) begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edges judged only on the synchronised copy
	assign o_smp.level = sync_q;
	assign o_smp.fall = prev_q & ~sync_q & i_ce;
endmodule // pin_sampler
`default_nettype wire

// ---- src/reload_down_counter.sv ----
// Purpose: true divide-by-n down counter with reload and end pulse
// Assumes: an init of zero means full range (2**W)
// Notes: used for prescaler and main counter
`timescale 1ns/1ps
`default_nettype none
module reload_down_counter #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	// control
	input wire logic i_load,
	input wire logic i_step,
	input wire logic i_auto,
	input wire logic [W-1:0] i_init,
	// state
	output logic [W-1:0] o_count,
	output logic o_end
);
	logic [W-1:0] cnt_q;
	logic stop_q;
	logic at_one;

	if (W < 2) begin : g_bad_width
		$error("reload_down_counter needs W of at least 2");
	end

	assign at_one = (cnt_q == {{(W-1){1'b0}}, 1'b1});
	// end fires on the step that leaves one; a stopped counter is silent
	assign o_end = i_step & at_one & ~stop_q & ~i_load;
	assign o_count = cnt_q;

	// load beats stepping so a retrigger always restarts cleanly
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			cnt_q <= '0;
			stop_q <= 1'b1;
		end else if (i_ce) begin
			if (i_load) begin
				cnt_q <= i_init;
				stop_q <= 1'b0;
			end else if (i_step && !stop_q) begin
				if (at_one) begin
					cnt_q <= i_auto ? i_init : '0;
					stop_q <= ~i_auto;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule // reload_down_counter
`default_nettype wire

// ---- testbench/pin_partner.sv ----
// Purpose: pulse source on the timer input pin and load on the output pin
// Assumes: the input line idles high through a pull-up
// Notes: the bench calls falls and level; the load counts output changes
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	// clock
	input wire logic i_clk_sys,
	// load side
	input wire logic i_out_pin,
	// source side
	output logic o_in_pin
);
	int edges_seen = 0;
	logic last_q = 1'b1;

	// idle level of the pulled-up line
	initial o_in_pin = 1'b1;

	// load counts level changes, sampled away from the launching edge
	always @(negedge i_clk_sys) begin
		if (i_out_pin !== last_q)
			edges_seen++;
		last_q <= i_out_pin;
	end

	// pulses: both levels held long enough for the synchroniser
	task automatic falls(input int n, input int lo, input int hi);
		repeat (n) begin
			@(posedge i_clk_sys);
			o_in_pin <= 1'b0;
			repeat (lo) @(posedge i_clk_sys);
			o_in_pin <= 1'b1;
			repeat (hi) @(posedge i_clk_sys);
		end
	endtask

	// steady level, used as a gate
	task automatic level(input logic v);
		@(posedge i_clk_sys);
		o_in_pin <= v;
	endtask
endmodule // pin_partner
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the timer pin block
// Assumes: software side driven by tasks, pins by pin_partner
// Notes: counts of request pulses are compared as deltas per test
`timescale 1ns/1ps
`default_nettype none
`include "timer_pin_map.svh"
module testbench;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic i_ce = 1'b1;
	logic [7:0] i_reg_addr = 8'h00;
	logic i_reg_wr = 1'b0;
	logic [7:0] i_reg_wdata = 8'h00;
	logic [7:0] i_port_five_direction = 8'hff;
	logic i_port_data_wr = 1'b0;
	logic i_port_data_bit6 = 1'b0;
	logic [7:0] o_reg_rdata;
	logic o_port_bit6_level;
	logic o_timer_output_pin;
	logic o_timer_output_oe_n;
	logic o_count_end_request;
	logic o_input_edge_request;
	wire logic in_pin;
	int n_end = 0;
	int n_edge = 0;
	int err_total = 0;
	int checked = 0;

	timer_pin_io dut (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.i_port_five_direction(i_port_five_direction),
		.i_port_data_wr(i_port_data_wr),
		.i_port_data_bit6(i_port_data_bit6),
		.o_port_bit6_level(o_port_bit6_level),
		.i_timer_input_pin(in_pin),
		.o_timer_output_pin(o_timer_output_pin),
		.o_timer_output_oe_n(o_timer_output_oe_n),
		.o_count_end_request(o_count_end_request),
		.o_input_edge_request(o_input_edge_request)
	);

	pin_partner src (
		.i_clk_sys(i_clk_sys),
		.i_out_pin(o_timer_output_pin),
		.o_in_pin(in_pin)
	);

	// 100 MHz clock
	initial begin
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// request pulses counted on the falling edge, clear of updates
	always @(negedge i_clk_sys) begin
		if (o_count_end_request === 1'b1)
			n_end++;
		if (o_input_edge_request === 1'b1)
			n_edge++;
	end

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// settle one step past the edge so registered outputs have landed
	task automatic cycles(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		cycles(2);
		v = o_reg_rdata;
	endtask

	task automatic port_write(input logic d);
		@(posedge i_clk_sys);
		i_port_data_bit6 <= d;
		i_port_data_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_port_data_wr <= 1'b0;
	endtask

	// prescaler first, then initial count, then mode
	task automatic setup(input logic [7:0] p, input logic [7:0] c,
		input logic [7:0] m);
		reg_write(`OFS_PRESCALER_CONFIG, p);
		reg_write(`OFS_MAIN_DOWN_COUNTER, c);
		reg_write(`OFS_TIMER_MODE_CONTROL, m);
	endtask

	task automatic wait_end(input int bound);
		int start;
		start = n_end;
		repeat (bound) begin
			if (n_end != start)
				return;
			@(posedge i_clk_sys);
		end
		err_total++;
		$display("wrong value end wait expected request seen none");
		report_and_stop();
	endtask

	task automatic t_reset;
		logic [7:0] v;
		reg_read(`OFS_TIMER_MODE_CONTROL, v);
		check("mode reset", v, `TMC_RESET);
		reg_read(`OFS_PRESCALER_CONFIG, v);
		check("prescaler reset", v, `PRE_RESET);
		reg_read(`OFS_MAIN_DOWN_COUNTER, v);
		check("counter reset", v, `CNT_RESET);
		reg_read(8'he0, v);
		check("unmapped read", v, 8'h00);
		check("pin reset", {7'h00, o_timer_output_pin}, 8'h01);
		// bit six output, bit two input
		@(posedge i_clk_sys);
		i_port_five_direction <= 8'h04;
		cycles(3);
		check("output enable", {7'h00, o_timer_output_oe_n}, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_ext;
		logic [7:0] v;
		int be;
		int bg;
		// modulo 2 keeps bit 2 clear, i.e. external source
		setup(8'h09, 8'h01, 8'h8c);
		cycles(4);
		reg_read(`OFS_TIMER_MODE_CONTROL, v);
		check("load cleared", v, 8'h88);
		check("toggle preset", {7'h00, o_timer_output_pin}, 8'h01);
		be = n_end;
		bg = n_edge;
		for (int i = 1; i <= 2; i++) begin
			src.falls(2, 4, 4);
			cycles(6);
			check("ext ends", 8'(n_end - be), 8'(i));
			check("toggle", {7'h00, o_timer_output_pin}, 8'(i - 1));
		end
		check("edge requests", 8'(n_edge - bg), 8'h04);
		$display("test external done");
	endtask

	task automatic t_div64;
		int be;
		setup(8'h01, 8'h01, 8'h0c);
		be = n_end;
		src.falls(63, 4, 4);
		cycles(6);
		check("div64 early", 8'(n_end - be), 8'h00);
		src.falls(1, 4, 4);
		cycles(6);
		check("div64 end", 8'(n_end - be), 8'h01);
		$display("test divide by 64 done");
	endtask

	task automatic t_gated;
		int be;
		int bg;
		src.level(1'b0);
		setup(8'h09, 8'h02, 8'h1c);
		be = n_end;
		cycles(200);
		check("gate closed", 8'(n_end - be), 8'h00);
		src.level(1'b1);
		cycles(160);
		be = n_end - be;
		check("gate open", {7'h00, be >= 9 && be <= 11}, 8'h01);
		bg = n_edge;
		src.level(1'b0);
		cycles(8);
		check("gate end edge", 8'(n_edge - bg), 8'h01);
		be = n_end;
		cycles(100);
		check("gate paused", 8'(n_end - be), 8'h00);
		$display("test gated done");
	endtask

	task automatic t_trig;
		logic [7:0] v;
		int be;
		src.level(1'b1);
		setup(8'h08, 8'h02, 8'h28);
		// a gated end from the previous test may still be in flight
		cycles(2);
		be = n_end;
		cycles(50);
		check("no trigger", 8'(n_end - be), 8'h00);
		src.falls(1, 4, 4);
		wait_end(100);
		cycles(4);
		reg_read(`OFS_TIMER_MODE_CONTROL, v);
		check("enable cleared", v & 8'h08, 8'h00);
		reg_read(`OFS_MAIN_DOWN_COUNTER, v);
		check("rest at zero", v, 8'h00);
		src.falls(3, 4, 4);
		cycles(40);
		check("edges ignored", 8'(n_end - be), 8'h01);
		$display("test triggered done");
	endtask

	task automatic t_retrig;
		int be;
		setup(8'h09, 8'h04, 8'h38);
		be = n_end;
		src.falls(5, 4, 16);
		check("retrigger held", 8'(n_end - be), 8'h00);
		cycles(50);
		be = n_end - be;
		check("retrigger end", {7'h00, be >= 1 && be <= 2}, 8'h01);
		$display("test retrigger done");
	endtask

	task automatic t_outsel;
		logic p;
		int bt;
		reg_write(`OFS_TIMER_MODE_CONTROL, 8'h00);
		port_write(1'b0);
		cycles(3);
		check("data pin", {7'h00, o_timer_output_pin}, 8'h00);
		check("port level", {7'h00, o_port_bit6_level}, 8'h00);
		reg_write(`OFS_TIMER_MODE_CONTROL, 8'h40);
		cycles(3);
		check("other sel pin", {7'h00, o_timer_output_pin}, 8'h00);
		reg_write(`OFS_TIMER_MODE_CONTROL, 8'h80);
		cycles(3);
		p = o_timer_output_pin;
		port_write(~p);
		cycles(3);
		check("port ignored", {7'h00, o_timer_output_pin}, {7'h00, p});
		check("port readback", {7'h00, o_port_bit6_level}, {7'h00, p});
		reg_write(`OFS_TIMER_MODE_CONTROL, 8'hc0);
		cycles(3);
		bt = src.edges_seen;
		cycles(10);
		check("clock out", 8'(src.edges_seen - bt), 8'h0a);
		$display("test output select done");
	endtask

	// reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		t_reset();
		t_ext();
		t_div64();
		t_gated();
		t_trig();
		t_retrig();
		t_outsel();
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
